// *** core/umcs_cfg.svh ***
// offsets, field positions, reset values and counts of the modem block
`ifndef UMCS_CFG_SVH
`define UMCS_CFG_SVH

// register offsets on the 3-bit host address
`define UMCS_OFF_RXD 3'h0
`define UMCS_OFF_IER 3'h1
`define UMCS_OFF_MCTL 3'h4
`define UMCS_OFF_LSR 3'h5
`define UMCS_OFF_MSR 3'h6

// field positions
`define UMCS_IER_MSI  3
`define UMCS_MCTL_DTR  0
`define UMCS_MCTL_RTS  1
`define UMCS_MCTL_OUTA 2
`define UMCS_MCTL_OUTB 3
`define UMCS_MCTL_LOOP 4
`define UMCS_MSR_TRAIL 2
`define UMCS_MSR_RING  6
`define UMCS_LSR_DR 0
`define UMCS_LSR_OE 1

// reset values
`define UMCS_MCTL_RST 5'h00
`define UMCS_IER_RST 1'h0

// receiver timing in 16x ticks, and index of the last data bit
`define UMCS_TICK_MID  4'h7
`define UMCS_TICK_BIT  4'hf
`define UMCS_LAST_BIT  3'h7

`endif

// *** core/umcs_pkg.sv ***
// types shared by the modem control and status block
package umcs_pkg;

   // one host register access, all fields sampled in one cycle
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } umcs_req_t;

   // receiver frame states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } umcs_rx_t;

endpackage

// *** core/umcs_top.sv ***
// modem control, modem status and 16x receiver of the serial element
//
// Overview of operation
// - writing one to a user output control bit drives that pin active
// - user outputs inactive high on reset, in loop mode, or bit cleared
// - receiver samples serial input on a 16x bit-rate clock from outside
// - status read returns ring indicator condition in bit 6
// - status bit 2 set after ring input rose since last status read
// - enabled modem status interrupt raised on ring rising transition
// - request-to-send pin active while its control bit is set
// - request-to-send inactive high on reset, in loop mode, or bit cleared
// - serial output forced to marking (one) on master reset
`include "umcs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module umcs_top (
   // clock, reset, enable
   input  wire logic              mclk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   // host register port
   input  wire umcs_pkg::umcs_req_t host_req_i,
   output logic [7:0]             rd_data_o,
   output logic                   irq_o,
   // modem and serial pins
   input  wire logic              ring_indicator_input_n_i,
   input  wire logic              serial_in_pin_i,
   input  wire logic              rclk_i,
   output logic                   serial_out_pin_o,
   output logic                   dtr_n_o,
   output logic                   rts_n_o,
   output logic                   user_output_a_n_o,
   output logic                   user_output_b_n_o
);

   // limits a user must know:
   // - the receive clock is sampled, not used as a clock, so each of its
   //   phases must last at least three cycles of the main clock
   // - the ring pin passes two flops and an edge stage, so a rising edge
   //   reaches the status flag three cycles after it happens
   // - a ring pulse shorter than one main clock cycle may be missed
   // - loop mode parks every modem control pin at its inactive level
   //   and feeds the receiver from the idle serial output
   // - a byte whose stop bit reads low is dropped without a flag
   // - the serial output idles at marking, there is no transmitter here
   // - a clear by a read never hides an edge seen in that same cycle
   // - with the clock enable low nothing is taken and nothing moves,
   //   only the synchronous reset still acts

   // address match, shared by every register strobe
   function automatic logic sel(input logic [2:0] a,
                                input logic [2:0] o);
      return a == o;
   endfunction

   // pin synchronisers: stage 1 feeds stage 2 only
   // the third stage of ring and receive clock only serves edge detects,
   // so no logic ever looks at a possibly metastable first stage
   logic ring_s1;
   logic ring_s2;
   logic ring_s3;
   logic ser_s1;
   logic ser_s2;
   logic rc_s1;
   logic rc_s2;
   logic rc_s3;

   // host visible state
   logic [4:0] mctl;
   logic       ier_msi;
   logic       trail;
   logic [7:0] rxd;
   logic       dr;
   logic       oe;

   // receiver state
   umcs_pkg::umcs_rx_t rx_st;
   umcs_pkg::umcs_rx_t next_rx_st;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [2:0] idx;
   logic [2:0] next_idx;
   logic [7:0] shf;
   logic [7:0] next_shf;
   logic       rx_done;

   // next values of host visible state
   logic [4:0] next_mctl;
   logic       next_ier_msi;
   logic       next_trail;
   logic [7:0] next_rxd;
   logic       next_dr;
   logic       next_oe;
   logic       loop_on;

   // decoded strobes
   // strobes are not gated by the enable here: every flop that they
   // feed already holds while the enable is low
   wire logic wr_mctl = host_req_i.wr & sel(host_req_i.addr, `UMCS_OFF_MCTL);
   wire logic wr_ier = host_req_i.wr & sel(host_req_i.addr, `UMCS_OFF_IER);
   wire logic rd_msr = host_req_i.rd & sel(host_req_i.addr, `UMCS_OFF_MSR);
   wire logic rd_rxd = host_req_i.rd & sel(host_req_i.addr, `UMCS_OFF_RXD);
   wire logic rd_lsr = host_req_i.rd & sel(host_req_i.addr, `UMCS_OFF_LSR);
   wire logic rd_ier = host_req_i.rd & sel(host_req_i.addr, `UMCS_OFF_IER);
   wire logic rd_mctl = host_req_i.rd & sel(host_req_i.addr, `UMCS_OFF_MCTL);

   // edge detects look only at synchronised stages
   wire logic ring_rise = ring_s2 & ~ring_s3;  // pin low to high
   wire logic tick     = rc_s2 & ~rc_s3;   // one 16x period

   // loop mode keeps the receiver on the idle line
   wire logic rx_in = loop_on ? serial_out_pin_o : ser_s2;

   // register images for reads
   wire logic [7:0] msr_val = {1'b0, ~ring_s2, 3'h0, trail, 2'h0};
   wire logic [7:0] lsr_val = {6'h00, oe, dr};
   wire logic [7:0] ier_val = {4'h0, ier_msi, 3'h0};
   wire logic [7:0] mctl_val = {3'h0, mctl};

   // read mux; unmapped offsets read zero
   wire logic [7:0] rd_mux =
      rd_msr ? msr_val :
      rd_lsr ? lsr_val :
      rd_rxd ? rxd     :
      rd_ier ? ier_val :
      rd_mctl ? mctl_val : 8'h00;

   // control and status next values
   always_comb begin
      // only the five defined control bits are kept
      next_mctl    = wr_mctl ? host_req_i.wdata[4:0] : mctl;
      next_ier_msi = wr_ier ? host_req_i.wdata[`UMCS_IER_MSI] : ier_msi;
      loop_on      = mctl[`UMCS_MCTL_LOOP];
      // a rising edge in the read cycle survives the clear, so software
      // that reads while the line moves never loses an event
      next_trail   = ring_rise | (trail & ~rd_msr);
      next_rxd     = rx_done ? shf : rxd;
      // new byte wins over the clear by a data read
      next_dr      = rx_done | (dr & ~rd_rxd);
      // overrun: byte lands while the old one is unread
      next_oe      = (rx_done & dr & ~rd_rxd) | (oe & ~rd_lsr);
   end

   // receiver: start check at mid bit, then one sample per bit
   always_comb begin
      next_rx_st = rx_st;
      next_cnt   = 4'(cnt + 4'h1);
      next_idx   = idx;
      next_shf   = shf;
      rx_done    = 1'b0;
      if (!tick) begin
         next_cnt = cnt;
      end else begin
         case (rx_st)
            umcs_pkg::RX_IDLE: begin
               next_cnt = 4'h0;
               if (!rx_in) begin
                  next_rx_st = umcs_pkg::RX_START;
               end
            end
            umcs_pkg::RX_START: begin
               if (cnt == `UMCS_TICK_MID) begin
                  // a glitch shorter than half a bit is not a start
                  next_rx_st = rx_in ? umcs_pkg::RX_IDLE
                                     : umcs_pkg::RX_DATA;
                  next_cnt   = 4'h0;
                  next_idx   = 3'h0;
               end
            end
            umcs_pkg::RX_DATA: begin
               if (cnt == `UMCS_TICK_BIT) begin
                  next_shf = {rx_in, shf[7:1]};   // lsb first
                  next_cnt = 4'h0;
                  next_idx = 3'(idx + 3'h1);
                  if (idx == `UMCS_LAST_BIT) begin
                     next_rx_st = umcs_pkg::RX_STOP;
                  end
               end
            end
            umcs_pkg::RX_STOP: begin
               if (cnt == `UMCS_TICK_BIT) begin
                  next_rx_st = umcs_pkg::RX_IDLE;
                  next_cnt   = 4'h0;
                  // a missing stop bit drops the byte
                  rx_done    = rx_in;
               end
            end
            default: begin
               next_rx_st = umcs_pkg::RX_IDLE;
               next_cnt   = 4'h0;
            end
         endcase
      end
   end

   // synchronisers, reset to the idle pin levels
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ring_s1 <= 1'h1;
         ring_s2 <= 1'h1;
         ring_s3 <= 1'h1;
         ser_s1  <= 1'h1;
         ser_s2  <= 1'h1;
         rc_s1  <= 1'h0;
         rc_s2  <= 1'h0;
         rc_s3  <= 1'h0;
      end else if (ce_i) begin
         ring_s1 <= ring_indicator_input_n_i;
         ring_s2 <= ring_s1;
         ring_s3 <= ring_s2;
         ser_s1  <= serial_in_pin_i;
         ser_s2  <= ser_s1;
         rc_s1  <= rclk_i;
         rc_s2  <= rc_s1;
         rc_s3  <= rc_s2;
      end
   end

   // host registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mctl    <= `UMCS_MCTL_RST;
         ier_msi <= `UMCS_IER_RST;
         trail   <= 1'h0;
         rxd     <= 8'h00;
         dr      <= 1'h0;
         oe      <= 1'h0;
      end else if (ce_i) begin
         mctl    <= next_mctl;
         ier_msi <= next_ier_msi;
         trail   <= next_trail;
         rxd     <= next_rxd;
         dr      <= next_dr;
         oe      <= next_oe;
      end
   end

   // receiver registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_st <= umcs_pkg::RX_IDLE;
         cnt   <= 4'h0;
         idx   <= 3'h0;
         shf   <= 8'h00;
      end else if (ce_i) begin
         rx_st <= next_rx_st;
         cnt   <= next_cnt;
         idx   <= next_idx;
         shf   <= next_shf;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= 8'h00;
      end else if (ce_i) begin
         rd_data_o <= host_req_i.rd ? rd_mux : 8'h00;
      end
   end

   // modem pins from next values so they follow a write by one edge;
   // loop mode forces every control pin inactive high
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         dtr_n_o           <= 1'h1;
         rts_n_o           <= 1'h1;
         user_output_a_n_o <= 1'h1;
         user_output_b_n_o <= 1'h1;
         serial_out_pin_o  <= 1'h1;
         irq_o             <= 1'h0;
      end else if (ce_i) begin
         // pins use the next value so a write shows one edge later,
         // at the cost of a little more logic ahead of these flops
         dtr_n_o <= ~(next_mctl[`UMCS_MCTL_DTR]
                      & ~next_mctl[`UMCS_MCTL_LOOP]);
         rts_n_o <= ~(next_mctl[`UMCS_MCTL_RTS]
                      & ~next_mctl[`UMCS_MCTL_LOOP]);
         user_output_a_n_o <= ~(next_mctl[`UMCS_MCTL_OUTA]
                                & ~next_mctl[`UMCS_MCTL_LOOP]);
         user_output_b_n_o <= ~(next_mctl[`UMCS_MCTL_OUTB]
                                & ~next_mctl[`UMCS_MCTL_LOOP]);
         // no transmitter here, so the line idles at marking
         serial_out_pin_o  <= 1'h1;
         irq_o             <= next_trail & next_ier_msi;
      end
   end

endmodule // umcs_top

`default_nettype wire

// *** dv/tb.sv ***
// bench for the modem control and status block
`include "umcs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk_i, sys_rst_i, ce_i, ring_on, took, irq_o, ring_n, ser_in, rclk;
   logic ser_out, dtr_n, rts_n, ua_n, ub_n, tx_go;
   umcs_pkg::umcs_req_t host_req_i;
   logic [7:0] rd_data_o, d, tx_byte;
   logic [7:0] exp_q[$];
   logic [3:0] e;
   integer fail_count, tests_run, seed, i;
   umcs_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .host_req_i(host_req_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
      .ring_indicator_input_n_i(ring_n), .serial_in_pin_i(ser_in),
      .rclk_i(rclk), .serial_out_pin_o(ser_out), .dtr_n_o(dtr_n),
      .rts_n_o(rts_n), .user_output_a_n_o(ua_n), .user_output_b_n_o(ub_n));
   umcs_modem_model modem (.mclk_i(mclk_i), .ring_on_i(ring_on),
      .tx_go_i(tx_go), .tx_byte_i(tx_byte),
      .ring_indicator_input_n_o(ring_n), .serial_in_pin_o(ser_in),
      .rclk_o(rclk));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = !mclk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] ex);
      tests_run = tests_run + 1;
      if (seen !== ex) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, ex);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one access, held only for its taking edge
   task automatic acc(input logic [2:0] a, input logic [7:0] v, input logic w);
      @(posedge mclk_i);
      host_req_i <= {a, v, w, !w};
      @(posedge mclk_i);
      host_req_i <= '0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] ex);
      exp_q.push_back(ex);
      acc(a, 8'h00, 1'b0);
   endtask
   task automatic pins(input logic [4:0] ex);
      check({3'h0, dtr_n, rts_n, ua_n, ub_n, ser_out}, {3'h0, ex});
   endtask
   // read data stand only in the cycle after the read
   always @(posedge mclk_i) begin
      if (took)
         check(rd_data_o, exp_q.pop_front());
      took <= ce_i & host_req_i.rd;
   end
   initial begin
      fail_count = 0; tests_run = 0; seed = 32'h8992; took = 1'b0;
      sys_rst_i = 1'b1; ce_i = 1'b1; ring_on = 1'b0; host_req_i = '0;
      tx_go = 1'b0; tx_byte = 8'h00;
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      pins(5'h1f);
      $display("reset test done");
      // random control words, loop bit among them
      for (i = 0; i < 8; i = i + 1) begin
         d = $random(seed) & 8'h1f;
         e = ~({d[0], d[1], d[2], d[3]} & {4{!d[4]}});
         acc(`UMCS_OFF_MCTL, d, 1'b1);
         pins({e, 1'b1});
         rd(`UMCS_OFF_MCTL, d);
      end
      $display("control test done");
      acc(`UMCS_OFF_IER, 8'h08, 1'b1);
      ring_on <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rd(`UMCS_OFF_MSR, 8'h40);
      ring_on <= 1'b0;
      for (i = 0; i < 20 && irq_o !== 1'b1; i = i + 1) begin
         @(posedge mclk_i);
         #1;
      end
      check({7'h0, irq_o}, 8'h01);
      if (i == 20) complete_run;
      repeat (8) @(posedge mclk_i);
      rd(`UMCS_OFF_MSR, 8'h04);
      rd(`UMCS_OFF_MSR, 8'h00);
      check({7'h0, irq_o}, 8'h00);
      // masked: flag still set, no request
      acc(`UMCS_OFF_IER, 8'h00, 1'b1);
      ring_on <= 1'b1;
      repeat (8) @(posedge mclk_i);
      ring_on <= 1'b0;
      repeat (8) @(posedge mclk_i);
      #1;
      check({7'h0, irq_o}, 8'h00);
      rd(`UMCS_OFF_MSR, 8'h04);
      rd(`UMCS_OFF_LSR, 8'h00);
      // one random frame on the serial input, loop mode off
      d = d & 8'h0f;
      acc(`UMCS_OFF_MCTL, d, 1'b1);
      tx_byte <= 8'($random(seed));
      tx_go <= 1'b1;
      repeat (1800) @(posedge mclk_i);
      tx_go <= 1'b0;
      rd(`UMCS_OFF_LSR, 8'h01);
      rd(`UMCS_OFF_RXD, tx_byte);
      $display("ring test done");
      ce_i <= 1'b0;
      acc(`UMCS_OFF_MCTL, 8'h02, 1'b1);
      ce_i <= 1'b1;
      rd(`UMCS_OFF_MCTL, d);
      rd(3'h7, 8'h00);
      acc(`UMCS_OFF_MCTL, 8'h0e, 1'b1);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      pins(5'h1f);
      rd(`UMCS_OFF_MCTL, 8'h00);
      repeat (2) @(posedge mclk_i);
      $display("enable and reset test done");
      complete_run;
   end
endmodule // tb
`default_nettype wire

// *** dv/umcs_modem_model.sv ***
// modem side: ring line, serial line with one frame per go, and 16x receive clock
`timescale 1ns/10ps
`default_nettype none
module umcs_modem_model #(
   parameter int RCLK_HALF_NS = 40
) (
   input  wire logic mclk_i,
   input  wire logic ring_on_i,
   input  wire logic tx_go_i,
   input  wire logic [7:0] tx_byte_i,
   output var logic  ring_indicator_input_n_o,
   output var logic  serial_in_pin_o,
   output var logic  rclk_o
);
   // ring line moves just after an edge, low while ringing
   always @(posedge mclk_i) ring_indicator_input_n_o <= !ring_on_i;
   // 16x bit clock runs free like a baud output
   initial begin
      ring_indicator_input_n_o = 1'b1;
      rclk_o = 1'b0;
      forever #(RCLK_HALF_NS) rclk_o = !rclk_o;
   end
   // one frame per rising go: start, eight bits lsb first, stop
   initial begin
      serial_in_pin_o = 1'b1;
      forever begin
         @(posedge tx_go_i);
         serial_in_pin_o <= 1'b0;
         repeat (16) @(posedge rclk_o);
         for (int b = 0; b < 8; b++) begin
            serial_in_pin_o <= tx_byte_i[b];
            repeat (16) @(posedge rclk_o);
         end
         serial_in_pin_o <= 1'b1;
      end
   end
endmodule // umcs_modem_model
`default_nettype wire

// *** dv/umcs_props.sv ***
// assertions on the modem control and status ports
`include "umcs_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module umcs_props (
   input wire logic                mclk_i,
   input wire logic                sys_rst_i,
   input wire logic                ce_i,
   input wire umcs_pkg::umcs_req_t host_req_i,
   input wire logic [7:0]          rd_data_o,
   input wire logic                irq_o,
   input wire logic                ring_indicator_input_n_i,
   input wire logic                serial_out_pin_o,
   input wire logic                rts_n_o,
   input wire logic                user_output_a_n_o,
   input wire logic                user_output_b_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   // accesses that the block takes
   wire logic [7:0] wd = host_req_i.wdata;
   wire logic rn = ring_indicator_input_n_i;
   wire logic w_mctl = ce_i & host_req_i.wr
                     & (host_req_i.addr == `UMCS_OFF_MCTL);
   wire logic r_msr = ce_i & host_req_i.rd
                    & (host_req_i.addr == `UMCS_OFF_MSR);
   property p_serial_out_pin; serial_out_pin_o; endproperty
   a_serial_out_pin: assert property (p_serial_out_pin) else $error("line not marking");
   property p_rts; w_mctl |=> rts_n_o == !($past(wd[1]) && !$past(wd[4]));
   endproperty
   a_rts: assert property (p_rts) else $error("rts pin wrong");
   property p_outa; w_mctl |=> user_output_a_n_o
      == !($past(wd[2]) && !$past(wd[4]));
   endproperty
   a_outa: assert property (p_outa) else $error("user a wrong");
   property p_outb; w_mctl |=> user_output_b_n_o
      == !($past(wd[3]) && !$past(wd[4]));
   endproperty
   a_outb: assert property (p_outb) else $error("user b wrong");
   // five steady samples let the synchroniser settle
   property p_ring; $stable(rn)[*5] ##0 r_msr |=> rd_data_o[6] == !$past(rn);
   endproperty
   a_ring: assert property (p_ring) else $error("ring bit wrong");
   property p_trail; r_msr && irq_o |=> rd_data_o[2]; endproperty
   a_trail: assert property (p_trail) else $error("edge flag lost");
   property p_irq; $rose(irq_o) |-> !$past(rn, 4) || !$past(rn, 5)
      || !$past(rn, 6) || !$past(rn, 7) || !$past(rn, 8); endproperty
   a_irq: assert property (p_irq) else $error("irq without ring edge");
   property p_clr; $stable(rn)[*8] ##0 r_msr |-> ##2 !irq_o; endproperty
   a_clr: assert property (p_clr) else $error("read left irq up");
endmodule // umcs_props
bind umcs_top umcs_props u_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .ce_i(ce_i), .host_req_i(host_req_i), .rd_data_o(rd_data_o),
   .irq_o(irq_o), .ring_indicator_input_n_i(ring_indicator_input_n_i),
   .serial_out_pin_o(serial_out_pin_o), .rts_n_o(rts_n_o),
   .user_output_a_n_o(user_output_a_n_o),
   .user_output_b_n_o(user_output_b_n_o));
`default_nettype wire
